// ### rtl/bus_ctrl.sv
// External bus-cycle controller: strobes, direction, multiplexed bus
`timescale 1ns/1ps
// Behaviour
// RQ1: Low reset pin restores initial state
// RQ2: Interrupt pin level and edge sensitive
// RQ3: Fetch flag marks opcode fetch cycles
// RQ4: Fetch flag overlaps fetch data strobe
// RQ5: Data strobe pulses on every transfer
// RQ6: Strobe runs at clock/5, stops low-power
// RQ7: Direction high read, low write
// RQ8: Direction driven for every target
// RQ9: Address strobe while low address out
// RQ10: Low address then data on shared bus
// RQ11: Upper address held through whole cycle
// RQ12: Address strobe first; direction stable
module bus_ctrl #(
    parameter int unsigned DEPTH = bus_ctrl_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_reset_pin_n,
    // Core requests
    input  wire logic        i_req_valid,
    input  wire logic        i_req_fetch,
    input  wire logic        i_req_read,
    input  wire logic [12:0] i_req_addr,
    input  wire logic [7:0]  i_req_wdata,
    output logic             o_req_ready,
    input  wire logic        i_low_power,
    // Read data and interrupt to core
    output logic             o_rd_valid,
    output logic [7:0]       o_rd_data,
    input  wire logic        i_irq_pin_n,
    output logic             o_irq_pending,
    input  wire logic        i_irq_ack,
    output logic             o_core_reset,
    // External bus
    output logic             o_address_latch_strobe,
    output logic             o_data_strobe,
    output logic             o_opcode_fetch_flag,
    output logic             o_rw,
    output logic [4:0]       o_upper_address_lines,
    output logic [7:0]       o_low_addr_data_bus,
    output logic             o_low_addr_data_bus_oe,
    input  wire logic [7:0]  i_low_addr_data_bus
);
    // ==========================================
    // Pin synchronisers
    // ==========================================
    logic [1:0] rst_sync_q;
    logic [1:0] irq_sync_q;
    logic [1:0] lp_sync_q;
    logic       irq_prev_q;
    always_ff @(posedge i_core_clk) begin
        rst_sync_q <= {rst_sync_q[0], i_reset_pin_n};
        irq_sync_q <= {irq_sync_q[0], i_irq_pin_n};
        lp_sync_q  <= {lp_sync_q[0], i_low_power};
    end
    // RQ1: pin reset merge
    wire rst_all = i_rst || !rst_sync_q[1];
    always_ff @(posedge i_core_clk) begin
        if (i_rst) o_core_reset <= 1'b1;
        else       o_core_reset <= !rst_sync_q[1];
    end
    // ==========================================
    // Interrupt request
    // ==========================================
    wire irq_level = !irq_sync_q[1];
    wire irq_fall  = irq_prev_q && !irq_sync_q[1];
    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            irq_prev_q    <= 1'b1;
            o_irq_pending <= 1'b0;
        end else begin
            irq_prev_q <= irq_sync_q[1];
            // RQ2: edge latch or level, set wins
            if (irq_fall || irq_level) o_irq_pending <= 1'b1;
            else if (i_irq_ack)        o_irq_pending <= 1'b0;
        end
    end
    // ==========================================
    // Request FIFO
    // ==========================================
    logic [bus_ctrl_pkg::REQ_W-1:0] head;
    logic                           head_valid;
    logic                           head_take;
    req_fifo #(.WIDTH(bus_ctrl_pkg::REQ_W), .DEPTH(DEPTH)) u_fifo (
        .i_core_clk  (i_core_clk),
        .i_rst       (rst_all),
        .i_in_valid  (i_req_valid),
        .i_in_data   ({i_req_fetch, i_req_read, i_req_addr, i_req_wdata}),
        .o_in_ready  (o_req_ready),
        .o_out_valid (head_valid),
        .o_out_data  (head),
        .i_out_ready (head_take)
    );
    // ==========================================
    // Bus cycle sequencer
    // ==========================================
    bus_ctrl_pkg::bus_state_t st_q;
    logic [2:0]  ph_q;
    logic        fetch_q;
    logic        real_q;
    logic [7:0]  wdata_q;
    logic [7:0]  laddr_q;
    wire         lowp    = lp_sync_q[1];
    wire         cyc_end = (ph_q == bus_ctrl_pkg::PH_LAST);
    // RQ6: strobe free-runs; dummy read cycle when idle
    wire         start   = !lowp && (st_q != bus_ctrl_pkg::ST_CYCLE || cyc_end);
    assign head_take = start && head_valid;
    wire [2:0]   ph_d    = start ? bus_ctrl_pkg::PH_ADDR : 3'(ph_q + 1'b1);
    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            st_q                   <= bus_ctrl_pkg::ST_IDLE;
            ph_q                   <= bus_ctrl_pkg::PH_ADDR;
            fetch_q                <= 1'b0;
            real_q                 <= 1'b0;
            wdata_q                <= 8'h00;
            laddr_q                <= 8'h00;
            o_rw                   <= bus_ctrl_pkg::RW_RESET;
            o_upper_address_lines  <= 5'h00;
        end else if (start) begin
            st_q    <= bus_ctrl_pkg::ST_CYCLE;
            ph_q    <= ph_d;
            fetch_q <= head_valid && head[22];
            // Dummy cycles must not hand read data to the core
            real_q  <= head_valid;
            // RQ7: direction per cycle; RQ8: all targets
            o_rw    <= head_valid ? head[21] : 1'b1;
            // RQ11: upper address held whole cycle
            o_upper_address_lines <= head_valid ? head[20:16] : 5'h00;
            laddr_q <= head_valid ? head[15:8] : 8'h00;
            wdata_q <= head_valid ? head[7:0] : 8'h00;
        end else if (st_q == bus_ctrl_pkg::ST_CYCLE && !cyc_end) begin
            ph_q <= ph_d;
        end else begin
            st_q <= lowp ? bus_ctrl_pkg::ST_LOWP : bus_ctrl_pkg::ST_IDLE;
        end
    end
    // ==========================================
    // Strobes and multiplexed bus
    // ==========================================
    wire in_cyc  = (st_q == bus_ctrl_pkg::ST_CYCLE);
    // RQ9: address strobe in phase one; RQ12: before data strobe
    wire als_d   = in_cyc && ph_q == bus_ctrl_pkg::PH_ADDR;
    // RQ5: data strobe phases three and four
    wire dstb_d  = in_cyc && ph_q >= bus_ctrl_pkg::PH_ALS_ON
                   && ph_q < bus_ctrl_pkg::PH_DSTB_ON + 3'h2
                   && ph_q != bus_ctrl_pkg::PH_ALS_ON;
    // RQ10: address out early, write data later
    wire addr_ph = in_cyc && ph_q <= bus_ctrl_pkg::PH_ALS_ON;
    wire oe_d    = addr_ph || (in_cyc && !o_rw && ph_q < bus_ctrl_pkg::PH_DSTB_OFF);
    always_ff @(posedge i_core_clk) begin
        if (rst_all) begin
            o_address_latch_strobe <= 1'b0;
            o_data_strobe          <= 1'b0;
            o_opcode_fetch_flag    <= 1'b0;
            o_low_addr_data_bus    <= 8'h00;
            o_low_addr_data_bus_oe <= 1'b0;
            o_rd_valid             <= 1'b0;
            o_rd_data              <= 8'h00;
        end else begin
            o_address_latch_strobe <= als_d;
            o_data_strobe          <= dstb_d;
            // RQ3: fetch flag; RQ4: spans the data strobe
            o_opcode_fetch_flag    <= in_cyc && fetch_q && ph_q != bus_ctrl_pkg::PH_LAST;
            o_low_addr_data_bus    <= addr_ph ? laddr_q : wdata_q;
            o_low_addr_data_bus_oe <= oe_d;
            o_rd_valid             <= in_cyc && real_q && o_rw && o_data_strobe && !dstb_d;
            if (o_data_strobe && !dstb_d) o_rd_data <= i_low_addr_data_bus;
        end
    end
endmodule : bus_ctrl

// ### rtl/bus_ctrl_pkg.sv
// Constants and types shared by the external bus-cycle controller
package bus_ctrl_pkg;
    // ==========================================
    // Bus cycle timing
    // ==========================================
    localparam int unsigned OSC_DIV       = 5;
    localparam logic [2:0]  PH_ADDR       = 3'h0;
    localparam logic [2:0]  PH_ALS_ON     = 3'h1;
    localparam logic [2:0]  PH_DSTB_ON    = 3'h2;
    localparam logic [2:0]  PH_DSTB_OFF   = 3'h4;
    localparam logic [2:0]  PH_LAST       = 3'h4;
    // ==========================================
    // Widths and reset values
    // ==========================================
    localparam int unsigned LOW_W         = 8;
    localparam int unsigned UP_W          = 5;
    localparam int unsigned REQ_W         = 1 + 1 + UP_W + LOW_W + LOW_W;
    localparam logic        RW_RESET      = 1'b1;
    localparam int unsigned FIFO_DEPTH    = 16;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CYCLE = 3'b010,
        ST_LOWP  = 3'b100
    } bus_state_t;
endpackage : bus_ctrl_pkg

// ### rtl/req_fifo.sv
// Request FIFO in front of the bus-cycle sequencer
`timescale 1ns/1ps
module req_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    // Fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = i_in_valid && o_in_ready;
    wire              pop  = o_out_valid && i_out_ready;
    // Count is one bit wider than the pointers so that full and empty differ
    assign o_in_ready  = cnt_q < (AW+1)'(DEPTH);
    assign o_out_valid = cnt_q != '0;
    assign o_out_data  = mem_q[rd_q];
    always_ff @(posedge i_core_clk) begin
        if (push) mem_q[wr_q] <= i_in_data;
    end
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= AW'(wr_q + 1'b1);
            if (pop)  rd_q <= AW'(rd_q + 1'b1);
            cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        end
    end
endmodule : req_fifo

// ### dv/bus_ctrl_props.sv
// Checker for the bus-cycle controller pins
`timescale 1ns/1ps
module bus_ctrl_props (
    input wire logic       i_core_clk,
    input wire logic       i_rst,
    input wire logic       i_reset_pin_n,
    input wire logic       i_irq_pin_n,
    input wire logic       i_low_power,
    input wire logic       o_core_reset,
    input wire logic       o_irq_pending,
    input wire logic       o_address_latch_strobe,
    input wire logic       o_data_strobe,
    input wire logic       o_opcode_fetch_flag,
    input wire logic       o_rw,
    input wire logic [4:0] o_upper_address_lines,
    input wire logic       o_low_addr_data_bus_oe
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst || !i_reset_pin_n);
    chk_strobe_width: assert property ($rose(o_data_strobe) |=> o_data_strobe ##1 !o_data_strobe)
        else $error("data strobe width wrong");
    chk_strobe_period: assert property (disable iff (i_rst || !i_reset_pin_n || i_low_power)
        $rose(o_data_strobe) |-> ##5 $rose(o_data_strobe)) else $error("strobe period wrong");
    chk_als_first: assert property ($rose(o_address_latch_strobe) |=> !o_address_latch_strobe
        ##1 $rose(o_data_strobe)) else $error("strobe order wrong");
    chk_addr_stable: assert property ($rose(o_address_latch_strobe) |=>
        ($stable(o_rw) && $stable(o_upper_address_lines))[*3]) else $error("cycle not stable");
    chk_addr_drive: assert property (o_address_latch_strobe |-> o_low_addr_data_bus_oe)
        else $error("address not driven");
    chk_dir_drive: assert property (o_data_strobe |-> o_low_addr_data_bus_oe == !o_rw)
        else $error("bus direction wrong");
    chk_fetch_overlap: assert property ($rose(o_opcode_fetch_flag) |->
        o_address_latch_strobe ##2 (o_data_strobe && o_opcode_fetch_flag)[*2]) else $error("flag");
    chk_pin_reset: assert property (disable iff (i_rst) !i_reset_pin_n[*4] |->
        o_core_reset && !o_data_strobe && o_rw) else $error("pin reset not applied");
    chk_irq_level: assert property (!i_irq_pin_n[*4] |-> o_irq_pending)
        else $error("irq not pending");
endmodule : bus_ctrl_props
bind bus_ctrl bus_ctrl_props bus_ctrl_props_i (.i_core_clk, .i_rst, .i_reset_pin_n,
    .i_irq_pin_n, .i_low_power, .o_core_reset, .o_irq_pending, .o_address_latch_strobe,
    .o_data_strobe, .o_opcode_fetch_flag, .o_rw, .o_upper_address_lines, .o_low_addr_data_bus_oe);

// ### dv/ext_mem_model.sv
// Far-side memory on the multiplexed bus; also resolves the bus wire level
`timescale 1ns/1ps
module ext_mem_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_als,
    input  wire logic       i_dstb,
    input  wire logic       i_rw,
    input  wire logic [4:0] i_up,
    input  wire logic [7:0] i_bus_out,
    input  wire logic       i_bus_oe,
    output logic [7:0]      o_bus
);
    logic [7:0]  mem [0:8191];
    logic [12:0] addr_q = 13'h0000;
    logic [7:0]  drv_q = 8'h00;
    initial begin
        for (int k = 0; k < 8192; k++) begin
            mem[k] = k[7:0] ^ 8'h5a;
        end
    end
    always @(posedge i_core_clk) begin
        if (i_als) addr_q <= {i_up, i_bus_out};
        // answer reads, capture writes; released bus keeps toggling
        drv_q <= (i_dstb && i_rw) ? mem[addr_q] : ~drv_q;
        if (i_dstb && !i_rw) mem[addr_q] <= i_bus_out;
    end
    assign o_bus = i_bus_oe ? i_bus_out : drv_q;
endmodule : ext_mem_model

// ### dv/mpu_external_bus_control_bench.sv
// Self-checking bench for the bus-cycle controller
`timescale 1ns/1ps
module mpu_external_bus_control_bench;
    typedef struct packed {logic rd; logic fe; logic [12:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    row_t rows [6] = '{{2'b00, 13'h0123, 8'h3c, 8'h00}, {2'b10, 13'h0123, 8'h00, 8'h3c},
        {2'b11, 13'h1f80, 8'h00, 8'hda}, {2'b00, 13'h1fff, 8'ha5, 8'h00},
        {2'b11, 13'h1fff, 8'h00, 8'ha5}, {2'b10, 13'h0001, 8'h00, 8'h5b}};
    logic clk = 0, rst = 1, pin_n = 1, v = 0, fe = 0, rd = 0, lp = 0, irq_n = 1, ack = 0;
    logic [12:0] a = 0;
    logic [7:0] wd = 0, rdat, lo, bus;
    logic rdy, rv, pend, cres, als, dstb, ff, rw, oe, hs, prev;
    logic [4:0] up;
    int err_count = 0, tests_run = 0, n;
    bus_ctrl #(.DEPTH(16)) bus_ctrl_i (.i_core_clk(clk), .i_rst(rst), .i_reset_pin_n(pin_n),
        .i_req_valid(v), .i_req_fetch(fe), .i_req_read(rd), .i_req_addr(a), .i_req_wdata(wd),
        .o_req_ready(rdy), .i_low_power(lp), .o_rd_valid(rv), .o_rd_data(rdat),
        .i_irq_pin_n(irq_n), .o_irq_pending(pend), .i_irq_ack(ack), .o_core_reset(cres),
        .o_address_latch_strobe(als), .o_data_strobe(dstb), .o_opcode_fetch_flag(ff), .o_rw(rw),
        .o_upper_address_lines(up), .o_low_addr_data_bus(lo), .o_low_addr_data_bus_oe(oe),
        .i_low_addr_data_bus(bus));
    ext_mem_model ext_mem_model_i (.i_core_clk(clk), .i_als(als), .i_dstb(dstb), .i_rw(rw),
        .i_up(up), .i_bus_out(lo), .i_bus_oe(oe), .o_bus(bus));
    initial forever #4 clk = ~clk;
    task automatic chk(input logic [12:0] s, input logic [12:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    task automatic until_hit(input logic [12:0] lim, input logic want_rv, input logic [12:0] wa);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(want_rv ? rv === 1'b1 : (als === 1'b1 && {up, lo} === wa)) && n < lim);
        if (n >= lim) begin
            err_count++;
            tally_and_finish();
        end
    endtask : until_hit
    // Ready is sampled mid-cycle so the edge that takes the word is the one seen
    task automatic send(input row_t r);
        {rd, fe, a, wd} <= {r.rd, r.fe, r.a, r.d};
        v <= 1;
        n = 0;
        do begin
            @(negedge clk);
            hs = rdy;
            @(posedge clk);
            n++;
        end while (hs !== 1'b1 && n < 300);
        if (hs !== 1'b1) begin
            err_count++;
            tally_and_finish();
        end
    endtask : send
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        foreach (rows[i]) begin
            send(rows[i]);
            v <= 0;
            until_hit(60, 0, rows[i].a);
            chk(rw, rows[i].rd);
            chk(ff, rows[i].fe);
            repeat (2) @(posedge clk);
            chk(dstb, 1);
            chk(oe, !rows[i].rd);
            if (!rows[i].rd) chk(lo, rows[i].d);
            if (rows[i].rd) until_hit(10, 1, 0);
            if (rows[i].rd) chk(rdat, rows[i].e);
        end
        lp <= 1;
        repeat (12) @(posedge clk);
        n = 0;
        repeat (20) @(posedge clk) n += dstb;
        chk(n, 0);
        for (int k = 0; k < 16; k++) send({2'b00, 13'h0040 + 13'(k), 8'(k), 8'h00});
        v <= 0;
        @(posedge clk);
        chk(rdy, 0);
        lp <= 0;
        repeat (20) @(posedge clk);
        n = 0;
        prev = dstb;
        repeat (50) begin
            @(posedge clk);
            n += (dstb && !prev);
            prev = dstb;
        end
        chk(n, 10);
        irq_n <= 0;
        repeat (5) @(posedge clk);
        chk(pend, 1);
        irq_n <= 1;
        repeat (5) @(posedge clk) ack <= 1;
        ack <= 0;
        repeat (2) @(posedge clk);
        chk(pend, 0);
        pin_n <= 0;
        repeat (6) @(posedge clk);
        chk({cres, dstb, rw}, 3'b101);
        pin_n <= 1;
        repeat (10) @(posedge clk);
        chk(cres, 0);
        tally_and_finish();
    end
endmodule : mpu_external_bus_control_bench
